// ### gdio_port.sv
// What this block does
// - Direction bit one makes the pin an output, zero an input.
// - Input pin with drive bit one and pull-up enabled gets pull-up.
// - Pull-up drops when drive bit cleared or pin made output.
// - Reset tri-states all pins with no pull-up, even without clock.
// - Output pin drives pad to its drive value bit.
// - Writing one to input register toggles drive bit; zero ignored.
// - Global pull-up disable turns off every pull-up.
// - Synchronised pad level readable in either direction.
// - Pad passes two sync flops, latch flop, then register, delay three to four cycles.
// - Written drive value of an output pin enters latch at write edge; reads lag one.
// - Deep sleep clamp forces digital input low.
// - Clamp bypassed for pins enabled as external interrupts.
// - Removing the clamp on a high pin shows as a transition.
// - Strobes shared per port; clock, clamp, pull-up disable global.
// - Input register reads pad level, writes toggle drive; drive and direction read/write.
module gdio_port #(
   parameter int PORTS = gdio_pkg::NUM_PORTS,
   parameter int WIDTH = gdio_pkg::PORT_WIDTH
) (
   input wire logic sys_clk, // I/O clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic [gdio_pkg::ADDR_WIDTH-1:0] regAddr, // Register address
   input wire logic [7:0] regWdata, // Write data
   input wire logic regWr, // Write strobe
   input wire logic regRd, // Read strobe
   output logic [7:0] regRdata, // Read data, cycle after read
   input wire logic sleepRequest, // Deep sleep clamp from sleep control
   input wire logic [PORTS*WIDTH-1:0] extIntEnable, // Pin interrupt enables
   input wire logic [PORTS*WIDTH-1:0] padIn, // Pad levels
   output logic [PORTS*WIDTH-1:0] padOut, // Pad output values
   output logic [PORTS*WIDTH-1:0] padOe, // Pad output enables
   output logic [PORTS*WIDTH-1:0] pullupEn, // Pull-up enables
   output logic [PORTS*WIDTH-1:0] clampedLevel // Digital input to interrupts
);
   typedef struct packed {
      logic [PORTS*WIDTH-1:0] portDirection;
      logic [PORTS*WIDTH-1:0] portDrive;
      logic globalPullupDisable;
      logic sleepClamp;
      logic [7:0] rdata;
   } gdio_port_state_t;
   gdio_port_state_t state;
   gdio_port_state_t next_state;
   logic [PORTS*WIDTH-1:0] pinInputAll;
   logic [PORTS*WIDTH-1:0] driveWrite;
   logic [PORTS*WIDTH-1:0] newDriveAll;
   logic [PORTS*WIDTH-1:0] padSync1;
   logic [PORTS*WIDTH-1:0] padSync2;
   localparam int ADDR_SLOT = gdio_pkg::ADDR_WIDTH - 2;
   logic [1:0] regSel;
   logic [ADDR_SLOT-1:0] portSel;

   assign regSel = regAddr[1:0];
   assign portSel = regAddr[gdio_pkg::ADDR_WIDTH-1:2];

   // Two-flop front end so pads never reach logic directly
   always_ff @(posedge sys_clk) begin
      padSync1 <= padIn;
      padSync2 <= padSync1;
   end

   always_comb begin
      next_state = state;
      driveWrite = '0;
      next_state.rdata = gdio_pkg::RESET_VALUE;
      for (int p = 0; p < PORTS; p++) begin
         if (regWr && portSel == ADDR_SLOT'(p)) begin
            case (regSel)
               gdio_pkg::REG_DIRECTION: begin
                  next_state.portDirection[p*WIDTH +: WIDTH] =
                     regWdata[WIDTH-1:0];
               end
               gdio_pkg::REG_DRIVE: begin
                  next_state.portDrive[p*WIDTH +: WIDTH] =
                     regWdata[WIDTH-1:0];
                  driveWrite[p*WIDTH +: WIDTH] = '1;
               end
               gdio_pkg::REG_INPUT: begin
                  // Ones toggle the drive bits, zeros leave them
                  next_state.portDrive[p*WIDTH +: WIDTH] =
                     state.portDrive[p*WIDTH +: WIDTH] ^
                     regWdata[WIDTH-1:0];
                  driveWrite[p*WIDTH +: WIDTH] = regWdata[WIDTH-1:0];
               end
               default: begin
               end
            endcase
         end
         if (regRd && portSel == ADDR_SLOT'(p)) begin
            case (regSel)
               gdio_pkg::REG_DIRECTION: next_state.rdata =
                  8'(state.portDirection[p*WIDTH +: WIDTH]);
               gdio_pkg::REG_DRIVE: next_state.rdata =
                  8'(state.portDrive[p*WIDTH +: WIDTH]);
               gdio_pkg::REG_INPUT: next_state.rdata =
                  8'(pinInputAll[p*WIDTH +: WIDTH]);
               default: begin
               end
            endcase
         end
      end
      // Global control sits in port 0's last register index, shared by every port
      if (regWr && regSel == gdio_pkg::REG_CONTROL
          && portSel == ADDR_SLOT'(0)) begin
         next_state.globalPullupDisable =
            regWdata[gdio_pkg::CTL_PULLUP_DISABLE_BIT];
      end
      if (regRd && regSel == gdio_pkg::REG_CONTROL
          && portSel == ADDR_SLOT'(0)) begin
         next_state.rdata = 8'({state.sleepClamp,
            state.globalPullupDisable});
      end
      next_state.sleepClamp = sleepRequest;
      if (sys_rst) begin
         next_state = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      state <= next_state;
   end

   assign newDriveAll = next_state.portDrive;
   assign regRdata = state.rdata;

   genvar i;
   generate
      for (i = 0; i < PORTS*WIDTH; i++) begin : gPin
         gdio_pin uPin (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .padIn(padSync2[i]),
            .direction(state.portDirection[i]),
            .driveValue(state.portDrive[i]),
            .pullupDisable(state.globalPullupDisable),
            .sleepClamp(state.sleepClamp),
            .extIntEnable(extIntEnable[i]),
            .driveWrite(driveWrite[i]),
            .newDrive(newDriveAll[i]),
            .pinInput(pinInputAll[i]),
            .padOut(padOut[i]),
            .padOe(padOe[i]),
            .pullupEn(pullupEn[i]),
            .clampedLevel(clampedLevel[i])
         );
      end
   endgenerate
endmodule

// ### gdio_pkg.sv
package gdio_pkg;
   localparam int PORT_WIDTH = 8;
   localparam int NUM_PORTS = 2;
   // Register indices within one port's slot
   localparam logic [1:0] REG_INPUT = 2'h0;
   localparam logic [1:0] REG_DIRECTION = 2'h1;
   localparam logic [1:0] REG_DRIVE = 2'h2;
   localparam logic [1:0] REG_CONTROL = 2'h3;
   localparam int ADDR_WIDTH = 4;
   // Control register field positions
   localparam int CTL_PULLUP_DISABLE_BIT = 0;
   localparam int CTL_SLEEP_CLAMP_BIT = 1;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   // Cycles a written drive value masks the pad path (output flop + 2 sync)
   localparam logic [1:0] DRIVE_HOLD_CYCLES = 2'h3;
endpackage

// ### gdio_pin.sv
module gdio_pin (
   input wire logic sys_clk, // I/O clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic padIn, // Pad level from the two-flop synchroniser
   input wire logic direction, // Direction bit
   input wire logic driveValue, // Drive value bit
   input wire logic pullupDisable, // Global pull-up disable
   input wire logic sleepClamp, // Deep sleep clamp request
   input wire logic extIntEnable, // Pin enabled as external interrupt
   input wire logic driveWrite, // Drive value written this cycle
   input wire logic newDrive, // Drive value being written
   output logic pinInput, // Synchronised pad level
   output logic padOut, // Pad output value
   output logic padOe, // Pad output enable
   output logic pullupEn, // Pull-up enable
   output logic clampedLevel // Digital input after clamp
);
   typedef struct packed {
      logic syncLatch;
      logic pinInput;
      logic padOut;
      logic padOe;
      logic pullupEn;
      logic clampedLevel;
      logic [1:0] holdCount;
   } gdio_pin_state_t;
   gdio_pin_state_t state;
   gdio_pin_state_t next_state;
   logic digitalIn;

   always_comb begin
      // Clamp forces input low ahead of the buffer unless interrupt-enabled
      digitalIn = padIn & ~(sleepClamp & ~extIntEnable);
      next_state = state;
      next_state.syncLatch = digitalIn;
      // Stale pad levels still in the sync flops must not overwrite it
      if (state.holdCount != 2'h0) begin
         next_state.syncLatch = state.syncLatch;
         next_state.holdCount = 2'(state.holdCount - 2'h1);
      end
      // A write of an output value loads the latch directly
      if (driveWrite && direction) begin
         next_state.syncLatch = newDrive;
         next_state.holdCount = gdio_pkg::DRIVE_HOLD_CYCLES;
      end
      next_state.pinInput = state.syncLatch;
      next_state.padOe = direction;
      next_state.padOut = direction & driveValue;
      next_state.pullupEn = ~direction & driveValue & ~pullupDisable;
      next_state.clampedLevel = digitalIn;
      if (sys_rst) begin
         next_state = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      state <= next_state;
   end

   assign pinInput = state.pinInput;
   assign padOut = state.padOut;
   // Reset gates the pad asynchronously so pins float without a clock
   assign padOe = state.padOe & ~sys_rst;
   assign pullupEn = state.pullupEn & ~sys_rst;
   assign clampedLevel = state.clampedLevel;
endmodule

// ### gdio_port_checker.sv
module gdio_port_checker #(
   parameter int PORTS = 2,
   parameter int WIDTH = 8
) (
   input wire logic sys_clk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic [gdio_pkg::ADDR_WIDTH-1:0] regAddr, // Address
   input wire logic [7:0] regWdata, // Data
   input wire logic regWr, // Write
   input wire logic regRd, // Read
   input wire logic [7:0] regRdata, // Read data
   input wire logic sleepRequest, // Sleep
   input wire logic [PORTS*WIDTH-1:0] extIntEnable, // Int enables
   input wire logic [PORTS*WIDTH-1:0] padOut, // Drive
   input wire logic [PORTS*WIDTH-1:0] padOe, // Enable
   input wire logic [PORTS*WIDTH-1:0] pullupEn, // Pull-up
   input wire logic [PORTS*WIDTH-1:0] clampedLevel // Clamped
);
   typedef struct packed {
      logic [PORTS*WIDTH-1:0] dir;
      logic [PORTS*WIDTH-1:0] drv;
      logic global_pullup_disable;
   } gdio_shadow_t;
   gdio_shadow_t s;
   gdio_shadow_t next_s;
   logic [3:0] b;
   assign b = {regAddr[2], 3'h0};
   always_comb begin
      next_s = s;
      if (regWr && !regAddr[3]) begin
         case (regAddr[1:0])
            2'h0: next_s.drv[b +: 8] = s.drv[b +: 8] ^ regWdata;
            2'h1: next_s.dir[b +: 8] = regWdata;
            2'h2: next_s.drv[b +: 8] = regWdata;
            default: next_s.global_pullup_disable = regAddr[2] ? s.global_pullup_disable : regWdata[0];
         endcase
      end
   end
   always_ff @(posedge sys_clk) begin
      s <= sys_rst ? '0 : next_s;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Reset gating holds even without the clock, so never disabled
   a_reset_tristate: assert property (disable iff (1'b0)
      sys_rst |-> (padOe | pullupEn) == '0) else $error("pad live in reset");
   a_dir_follow: assert property (padOe == $past(s.dir))
      else $error("enable wrong");
   a_drive_follow: assert property (
      padOut == $past(s.drv & s.dir)) else $error("drive wrong");
   a_pullup_follow: assert property (
      pullupEn == $past(~s.dir & s.drv & {PORTS*WIDTH{~s.global_pullup_disable}}))
      else $error("pull-up wrong");
   a_dir_readback: assert property (
      $past(regRd && !regAddr[3] && regAddr[1:0] == 2'h1)
      |-> regRdata == $past(s.dir[b +: 8])) else $error("dir read");
   a_drive_readback: assert property (
      $past(regRd && !regAddr[3] && regAddr[1:0] == 2'h2)
      |-> regRdata == $past(s.drv[b +: 8])) else $error("drive read");
   a_unmapped_zero: assert property (
      !$past(regRd) || $past(regAddr[3]) || $past(regAddr) == 4'h7
      |-> regRdata == 8'h00) else $error("stray read data");
   a_sleep_clamp: assert property (sleepRequest [*8] |->
      (clampedLevel & ~$past(extIntEnable)) == '0) else $error("clamp open");
   c_toggle: cover property (regWr && regAddr == 4'h0 && regWdata != 8'h00);
   c_sleep: cover property (sleepRequest && extIntEnable != '0);
   c_pud: cover property (s.global_pullup_disable && !padOe[0]);
endmodule

bind gdio_port gdio_port_checker #(.PORTS(PORTS), .WIDTH(WIDTH)) chk_u (
   .sys_clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
   .sleepRequest, .extIntEnable, .padOut, .padOe, .pullupEn, .clampedLevel);

// ### gdio_pad_model.sv
module gdio_pad_model (
   input wire logic sys_clk, // Clock
   input wire logic [15:0] padOut, // Drive value
   input wire logic [15:0] padOe, // Drive enable
   input wire logic [15:0] pullupEn, // Pull-up
   input wire logic [15:0] extDrive, // Outside level
   input wire logic [15:0] extEn, // Outside drives
   output logic [15:0] padLevel // Wire level
);
   timeunit 1ns;
   timeprecision 100ps;
   // Undriven pins wander so a missing pull-up cannot hide
   logic [15:0] wander = 16'hA5A5;
   always @(posedge sys_clk) wander <= ~wander;
   assign padLevel = padOe & padOut
      | ~padOe & extEn & extDrive
      | ~padOe & ~extEn & (pullupEn | wander);
endmodule

// ### general_digital_io_port_bench.sv
module general_digital_io_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic sleepRequest = 1'b0;
   logic [15:0] extIntEnable = 16'h0000;
   logic [15:0] extDrive = 16'h0000;
   logic [15:0] extEn = 16'h0000;
   logic [7:0] regRdata;
   logic [15:0] padIn, padOut, padOe, pullupEn, clampedLevel;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   always #10 sys_clk = ~sys_clk;
   gdio_port dut_u (.sys_clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd,
      .regRdata, .sleepRequest, .extIntEnable, .padIn, .padOut, .padOe,
      .pullupEn, .clampedLevel);
   gdio_pad_model pad_u (.sys_clk, .padOut, .padOe, .pullupEn, .extDrive,
      .extEn, .padLevel(padIn));
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(logic [3:0] a, logic [7:0] e);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 chk("read data", {8'h00, e}, {8'h00, regRdata});
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      idle(16);
      chk("reset pads", 16'h0000, padOe | pullupEn);
      sys_rst <= 1'b0;
      rd(4'h1, 8'h00);
      rd(4'h6, 8'h00);
      $display("test reset ended");
      wr(4'h2, 8'hFF);
      idle(1);
      chk("pull-up", 16'h00FF, pullupEn);
      idle(4);
      rd(4'h0, 8'hFF);
      wr(4'h3, 8'h01);
      idle(1);
      chk("pull-up off", 16'h0000, pullupEn);
      rd(4'h3, 8'h01);
      wr(4'h3, 8'h00);
      $display("test pull-up ended");
      wr(4'h1, 8'hFF);
      idle(1);
      chk("enable", 16'h00FF, padOe);
      chk("drive", 16'h00FF, padOut);
      chk("pull-up", 16'h0000, pullupEn);
      wr(4'h0, 8'h0F);
      rd(4'h0, 8'hF0);
      rd(4'h0, 8'hF0);
      wr(4'h0, 8'h00);
      idle(1);
      chk("drive", 16'h00F0, padOut);
      rd(4'h2, 8'hF0);
      $display("test output ended");
      wr(4'h5, 8'hAA);
      wr(4'h6, 8'h55);
      idle(1);
      chk("enable", 16'hAAFF, padOe);
      chk("pull-up", 16'h5500, pullupEn);
      chk("drive", 16'h00F0, padOut);
      rd(4'h7, 8'h00);
      rd(4'hB, 8'h00);
      $display("test second port ended");
      wr(4'h1, 8'h00);
      extDrive <= 16'h003C;
      extEn <= 16'h00FF;
      idle(6);
      rd(4'h0, 8'h3C);
      $display("test input ended");
      extDrive <= 16'h00FF;
      extIntEnable <= 16'h0001;
      sleepRequest <= 1'b1;
      idle(6);
      chk("clamp", 16'h0001, clampedLevel);
      rd(4'h3, 8'h02);
      sleepRequest <= 1'b0;
      idle(6);
      chk("wake", 16'h55FF, clampedLevel);
      $display("test sleep ended");
      // No edge follows, so only the asynchronous gating can float the pads
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      #1 chk("reset pads", 16'h0000, padOe | pullupEn);
      $display("test async reset ended");
      conclude();
   end
endmodule
